// *** include/gpio_pin_port_regs.svh ***
/*
 * Register map, reset values and field positions of the GPIO pin port.
 * Assumes inclusion by bare name from files that use these macros.
 */
`ifndef GPIO_PIN_PORT_REGS_SVH
`define GPIO_PIN_PORT_REGS_SVH

// ============================================================
// Widths
// ============================================================
`define GPP_PINS 16
`define GPP_DATA_W 32
`define GPP_ADDR_W 32
`define GPP_UPPER_W 16
`define GPP_GC_W 3

// ============================================================
// Register byte addresses on the config bus
// ============================================================
`define GPP_ADDR_ENABLE 32'h01b00000
`define GPP_ADDR_DIRECTION 32'h01b00004
`define GPP_ADDR_VALUE 32'h01b00008
`define GPP_ADDR_RISE_DELTA 32'h01b00010
`define GPP_ADDR_RISE_MASK 32'h01b00014
`define GPP_ADDR_FALL_DELTA 32'h01b00018
`define GPP_ADDR_FALL_MASK 32'h01b0001c
`define GPP_ADDR_GLOBAL_CTRL 32'h01b00020
`define GPP_ADDR_POLARITY 32'h01b00024

// ============================================================
// Reset values
// ============================================================
`define GPP_ENABLE_RST 16'h00ff
`define GPP_DIRECTION_RST 16'h0000
`define GPP_PIN_ZERO 16'h0000
`define GPP_GC_RST 3'h0
`define GPP_UPPER_ZERO 16'h0000
`define GPP_DATA_ZERO 32'h00000000

// ============================================================
// Global control fields
// ============================================================
`define GPP_GC_MODE_HI 1
`define GPP_GC_MODE_LO 0
`define GPP_GC_DMA_BIT 2
// Bus bit that carries the DMA enable on writes and reads
`define GPP_GC_DMA_WBIT 4
// Read-back zero padding above, and zero gap below, the DMA enable
`define GPP_GC_READ_PAD_W 27
`define GPP_GC_READ_GAP 2'h0

`endif

// *** include/gpio_pin_port_pkg.sv ***
/*
 * Types shared by the GPIO pin port.
 * Assumes compilation before any design file that names it.
 */
`default_nettype none

package gpio_pin_port_pkg;

	// ============================================================
	// Event generation modes
	// ============================================================
	typedef enum logic [1:0] {
		EVT_OFF,   // No events raised
		EVT_ANY,   // Pulse on every new masked transition
		EVT_ALL    // Pulse once all masked deltas are latched
	} event_mode_t;

endpackage : gpio_pin_port_pkg

`default_nettype wire

// *** hw/gpio_input_sync.sv ***
/*
 * Two-flop synchroniser and edge detector for the sixteen port pins.
 * Assumes pin levels are asynchronous to clock; reset is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_port_regs.svh"

module gpio_input_sync (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [`GPP_PINS-1:0] pin_async,
	output logic [`GPP_PINS-1:0] pin_level,
	output logic [`GPP_PINS-1:0] pin_rise,
	output logic [`GPP_PINS-1:0] pin_fall
);

	// ============================================================
	// Synchroniser and history
	// ============================================================
	logic [`GPP_PINS-1:0] meta_q; // First stage, read only by stage two
	logic [`GPP_PINS-1:0] sync_q; // Stable sampled level
	logic [`GPP_PINS-1:0] hist_q; // Level one cycle earlier

	// Shift the pins through three stages
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			meta_q <= `GPP_PIN_ZERO;
			sync_q <= `GPP_PIN_ZERO;
			hist_q <= `GPP_PIN_ZERO;
		end else begin
			meta_q <= pin_async;
			sync_q <= meta_q;
			hist_q <= sync_q;
		end
	end

	// Edges come from stable stages only, never the metastable one
	assign pin_level = sync_q;
	assign pin_rise = sync_q & ~hist_q;
	assign pin_fall = ~sync_q & hist_q;

endmodule : gpio_input_sync

`default_nettype wire

// *** hw/gpio_pin_port.sv ***
/*
 * Sixteen-pin general-purpose I/O port with config-bus registers,
 * delta capture and CPU / DMA event pulses.
 * Assumes a single-cycle config bus master and one 25 MHz clock.
 */
// Function
// - Sixteen pins, configured by enable and direction.
// - Pin acts as GPIO only when enabled.
// - Direction zero input, one output.
// - Direction ignored while pin disabled.
// - Output pin drives written value bit.
// - Input pin reads back sampled level.
// - Pins raise CPU and DMA events, modes.
// - Direction resets zero; upper bits read zero.
// - Eight-period input level raises event.
// - Pins seven to zero enabled after reset.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_port_regs.svh"

module gpio_pin_port (
	input wire logic clock,
	input wire logic sys_rst,
	// Config bus
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [`GPP_ADDR_W-1:0] cfg_addr,
	input wire logic [`GPP_DATA_W-1:0] cfg_wdata,
	output logic [`GPP_DATA_W-1:0] cfg_rdata,
	output logic cfg_ack,
	// Pins
	input wire logic [`GPP_PINS-1:0] port_input_pin,
	output logic [`GPP_PINS-1:0] port_output_pin,
	output logic [`GPP_PINS-1:0] port_output_en,
	// Events
	output logic cpu_event,
	output logic dma_event_target
);

	// ============================================================
	// Helper functions
	// ============================================================
	// Sticky flag update: hardware set wins over write-one-to-clear
	function automatic logic [`GPP_PINS-1:0] sticky_next(
		input logic [`GPP_PINS-1:0] cur,
		input logic [`GPP_PINS-1:0] set,
		input logic [`GPP_PINS-1:0] clr
	);
		sticky_next = (cur & ~clr) | set;
	endfunction : sticky_next

	// Widen a pin vector to a bus word, upper half zero
	function automatic logic [`GPP_DATA_W-1:0] widen(
		input logic [`GPP_PINS-1:0] v
	);
		widen = {`GPP_UPPER_ZERO, v};
	endfunction : widen

	// ============================================================
	// Registers
	// ============================================================
	logic [`GPP_PINS-1:0] pin_enable_q; // Per-pin GPIO enable
	logic [`GPP_PINS-1:0] pin_direction_q; // Per-pin direction
	logic [`GPP_PINS-1:0] pin_value_q; // Output latch
	logic [`GPP_PINS-1:0] rising_delta_q; // Latched rising edges
	logic [`GPP_PINS-1:0] rising_mask_q; // Rising event mask
	logic [`GPP_PINS-1:0] falling_delta_q; // Latched falling edges
	logic [`GPP_PINS-1:0] falling_mask_q; // Falling event mask
	logic [`GPP_GC_W-1:0] global_control_q; // Mode and DMA enable
	logic [`GPP_PINS-1:0] event_polarity_q; // Per-pin edge swap
	logic all_met_q; // Previous all-deltas condition
	logic [`GPP_PINS-1:0] rising_delta_d;
	logic [`GPP_PINS-1:0] falling_delta_d;

	// ============================================================
	// Pin sampling
	// ============================================================
	logic [`GPP_PINS-1:0] in_level; // Synchronised levels
	logic [`GPP_PINS-1:0] in_rise; // Raw rising edges
	logic [`GPP_PINS-1:0] in_fall; // Raw falling edges

	// Two flops ahead of any use; edge seen two cycles after pin
	gpio_input_sync u_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.pin_async(port_input_pin),
		.pin_level(in_level),
		.pin_rise(in_rise),
		.pin_fall(in_fall)
	);

	// ============================================================
	// Pin direction and drive
	// ============================================================
	wire [`GPP_PINS-1:0] is_output; // Enabled and set to drive
	wire [`GPP_PINS-1:0] is_input; // Enabled and sensing
	assign is_output = pin_enable_q & pin_direction_q;
	assign is_input = pin_enable_q & ~pin_direction_q;

	// Disabled pins are released; latch reaches only driving pins
	assign port_output_en = is_output;
	assign port_output_pin = pin_value_q & is_output;

	// ============================================================
	// Address decode
	// ============================================================
	wire sel_enable = cfg_addr == `GPP_ADDR_ENABLE;
	wire sel_direction = cfg_addr == `GPP_ADDR_DIRECTION;
	wire sel_value = cfg_addr == `GPP_ADDR_VALUE;
	wire sel_rise_delta = cfg_addr == `GPP_ADDR_RISE_DELTA;
	wire sel_rise_mask = cfg_addr == `GPP_ADDR_RISE_MASK;
	wire sel_fall_delta = cfg_addr == `GPP_ADDR_FALL_DELTA;
	wire sel_fall_mask = cfg_addr == `GPP_ADDR_FALL_MASK;
	wire sel_global = cfg_addr == `GPP_ADDR_GLOBAL_CTRL;
	wire sel_polarity = cfg_addr == `GPP_ADDR_POLARITY;
	wire wr = cfg_req & cfg_write; // Write strobe
	wire rd = cfg_req & ~cfg_write; // Read strobe
	wire [`GPP_PINS-1:0] wr_pins = cfg_wdata[`GPP_PINS-1:0];

	// ============================================================
	// Delta capture
	// ============================================================
	wire [`GPP_PINS-1:0] ev_rise; // Polarity-adjusted rising
	wire [`GPP_PINS-1:0] ev_fall; // Polarity-adjusted falling
	wire [`GPP_PINS-1:0] clr_rise; // Software clear of rising
	wire [`GPP_PINS-1:0] clr_fall; // Software clear of falling

	// Only enabled input pins report transitions
	assign ev_rise = is_input &
		((in_rise & ~event_polarity_q) | (in_fall & event_polarity_q));
	assign ev_fall = is_input &
		((in_fall & ~event_polarity_q) | (in_rise & event_polarity_q));
	assign clr_rise = (wr & sel_rise_delta) ? wr_pins : `GPP_PIN_ZERO;
	assign clr_fall = (wr & sel_fall_delta) ? wr_pins : `GPP_PIN_ZERO;
	assign rising_delta_d = sticky_next(rising_delta_q, ev_rise,
		clr_rise);
	assign falling_delta_d = sticky_next(falling_delta_q, ev_fall,
		clr_fall);

	// ============================================================
	// Event generation
	// ============================================================
	gpio_pin_port_pkg::event_mode_t mode;
	assign mode = gpio_pin_port_pkg::event_mode_t'(
		global_control_q[`GPP_GC_MODE_HI:`GPP_GC_MODE_LO]);

	// New masked transition this cycle
	wire any_new = |((ev_rise & rising_mask_q) |
		(ev_fall & falling_mask_q));
	// Every masked delta latched, with at least one mask bit set
	wire mask_set = |(rising_mask_q | falling_mask_q);
	wire all_met = mask_set &
		((rising_delta_d & rising_mask_q) == rising_mask_q) &
		((falling_delta_d & falling_mask_q) == falling_mask_q);
	logic fire; // Event decision for this cycle

	// Mode selects when a pulse is raised
	always_comb begin
		fire = 1'b0;
		unique case (mode)
			gpio_pin_port_pkg::EVT_OFF: fire = 1'b0;
			gpio_pin_port_pkg::EVT_ANY: fire = any_new;
			gpio_pin_port_pkg::EVT_ALL: fire = all_met & ~all_met_q;
			default: fire = 1'b0; // Unused code raises nothing
		endcase
	end

	// ============================================================
	// Read mux
	// ============================================================
	wire [`GPP_PINS-1:0] value_view; // Live value seen by software
	// Output pins echo the latch, input pins the sampled level
	assign value_view = (pin_value_q & is_output) |
		(in_level & is_input);
	wire [`GPP_DATA_W-1:0] gc_view = {{`GPP_GC_READ_PAD_W{1'b0}},
		global_control_q[`GPP_GC_DMA_BIT], `GPP_GC_READ_GAP,
		global_control_q[`GPP_GC_MODE_HI:`GPP_GC_MODE_LO]};
	wire [`GPP_DATA_W-1:0] rd_word =
		sel_enable ? widen(pin_enable_q) :
		sel_direction ? widen(pin_direction_q) :
		sel_value ? widen(value_view) :
		sel_rise_delta ? widen(rising_delta_q) :
		sel_rise_mask ? widen(rising_mask_q) :
		sel_fall_delta ? widen(falling_delta_q) :
		sel_fall_mask ? widen(falling_mask_q) :
		sel_global ? gc_view :
		sel_polarity ? widen(event_polarity_q) :
		`GPP_DATA_ZERO;

	// ============================================================
	// Configuration registers
	// ============================================================
	// Writes land at the request edge; reserved addresses touch nothing
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_enable_q <= `GPP_ENABLE_RST;
			pin_direction_q <= `GPP_DIRECTION_RST;
			pin_value_q <= `GPP_PIN_ZERO;
			rising_mask_q <= `GPP_PIN_ZERO;
			falling_mask_q <= `GPP_PIN_ZERO;
			global_control_q <= `GPP_GC_RST;
			event_polarity_q <= `GPP_PIN_ZERO;
		end else if (wr) begin
			if (sel_enable) pin_enable_q <= wr_pins;
			if (sel_direction) pin_direction_q <= wr_pins;
			if (sel_value) pin_value_q <= wr_pins;
			if (sel_rise_mask) rising_mask_q <= wr_pins;
			if (sel_fall_mask) falling_mask_q <= wr_pins;
			if (sel_global) global_control_q <= {
				cfg_wdata[`GPP_GC_DMA_WBIT],
				cfg_wdata[`GPP_GC_MODE_HI:`GPP_GC_MODE_LO]};
			if (sel_polarity) event_polarity_q <= wr_pins;
		end
	end

	// ============================================================
	// Status, events and bus answer
	// ============================================================
	// Deltas and event pulses update every cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rising_delta_q <= `GPP_PIN_ZERO;
			falling_delta_q <= `GPP_PIN_ZERO;
			all_met_q <= 1'b0;
			cpu_event <= 1'b0;
			dma_event_target <= 1'b0;
			cfg_ack <= 1'b0;
			cfg_rdata <= `GPP_DATA_ZERO;
		end else begin
			rising_delta_q <= rising_delta_d;
			falling_delta_q <= falling_delta_d;
			all_met_q <= all_met;
			// Edge to pulse is three cycles, well inside eight
			cpu_event <= fire;
			dma_event_target <= fire &
				global_control_q[`GPP_GC_DMA_BIT];
			cfg_ack <= cfg_req;
			cfg_rdata <= rd ? rd_word : `GPP_DATA_ZERO;
		end
	end

endmodule : gpio_pin_port

`default_nettype wire

// *** verif/gpio_pin_port_asserts.sv ***
/*
 * Checker for the GPIO pin port, bound to its top module.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_port_regs.svh"

module gpio_pin_port_asserts (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cfg_req,
	input wire logic cfg_write,
	input wire logic [`GPP_ADDR_W-1:0] cfg_addr,
	input wire logic [`GPP_DATA_W-1:0] cfg_wdata,
	input wire logic [`GPP_DATA_W-1:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic [`GPP_PINS-1:0] port_input_pin,
	input wire logic [`GPP_PINS-1:0] port_output_pin,
	input wire logic [`GPP_PINS-1:0] port_output_en,
	input wire logic cpu_event,
	input wire logic dma_event_target
);
	// ============================================================
	// Bus handshake and read data
	// ============================================================
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Value write: request edge, then the new latch shows
	sequence s_val_wr;
		cfg_req && cfg_write && (cfg_addr == `GPP_ADDR_VALUE);
	endsequence
	property p_ack; cfg_req |=> cfg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack after request");
	property p_ack_cause; cfg_ack |-> $past(cfg_req); endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("ack without request");
	property p_idle; !cfg_ack |-> cfg_rdata == 32'h00000000; endproperty
	a_idle: assert property (p_idle) else $error("read data while idle");
	property p_upper; cfg_ack |-> cfg_rdata[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_rsv;
		cfg_req && !cfg_write && (cfg_addr == 32'h01b0000c)
			|=> cfg_rdata == 32'h00000000;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved read nonzero");
	// ============================================================
	// Pins and events
	// ============================================================
	// A pin that is not driving must show zero on its output
	property p_oe; (port_output_pin & ~port_output_en) == 16'h0000; endproperty
	a_oe: assert property (p_oe) else $error("output without enable");
	property p_val_wr;
		s_val_wr |=> port_output_pin == ($past(cfg_wdata[15:0]) & port_output_en);
	endproperty
	a_val_wr: assert property (p_val_wr) else $error("output not written");
	// Checked while in reset, so its own disable overrides the default
	property p_rst;
		disable iff (1'b0) sys_rst |=> port_output_en == 16'h0000 && !cpu_event;
	endproperty
	a_rst: assert property (p_rst) else $error("pins driven after reset");
	property p_dma; dma_event_target |-> cpu_event; endproperty
	a_dma: assert property (p_dma) else $error("lone dma event");
endmodule : gpio_pin_port_asserts

bind gpio_pin_port gpio_pin_port_asserts u_chk (.clock(clock),
	.sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_write(cfg_write),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.cfg_ack(cfg_ack), .port_input_pin(port_input_pin),
	.port_output_pin(port_output_pin), .port_output_en(port_output_en),
	.cpu_event(cpu_event), .dma_event_target(dma_event_target));
`default_nettype wire

// *** verif/gpio_pin_model.sv ***
/*
 * Outside circuitry on the sixteen pins.
 * Assumes the bench sets the level that the outside source drives.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_model (
	input wire logic [15:0] port_output_pin,
	input wire logic [15:0] port_output_en,
	input wire logic [15:0] ext_level,
	output logic [15:0] pin_wire
);
	// ============================================================
	// Wire resolution
	// ============================================================
	// Port wins where it drives; source levels held long by the bench
	assign pin_wire = (port_output_en & port_output_pin) |
		(~port_output_en & ext_level);
endmodule : gpio_pin_model
`default_nettype wire

// *** verif/gpio_pin_port_tb.sv ***
/*
 * Self-checking bench for the GPIO pin port.
 * Assumes the design, its header and the pin model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_port_regs.svh"

module gpio_pin_port_tb;
	// ============================================================
	// Signals
	// ============================================================
	logic clock, sys_rst, cfg_req, cfg_write, cfg_ack, cpu_event, dma_ev;
	logic [31:0] cfg_addr, cfg_wdata, cfg_rdata, rd, e;
	logic [15:0] out_pin, oe, pin_wire, ext_level;
	int bad_count, checks, ne, nd, m;

	gpio_pin_port dut (.clock(clock), .sys_rst(sys_rst), .cfg_req(cfg_req),
		.cfg_write(cfg_write), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .port_input_pin(pin_wire),
		.port_output_pin(out_pin), .port_output_en(oe),
		.cpu_event(cpu_event), .dma_event_target(dma_ev));
	gpio_pin_model pins (.port_output_pin(out_pin), .port_output_en(oe),
		.ext_level(ext_level), .pin_wire(pin_wire));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Event pulses counted per test window, off the launching edge
	always @(negedge clock) begin
		if (cpu_event === 1'b1) ne++;
		if (dma_ev === 1'b1) nd++;
	end

	// ============================================================
	// Tasks
	// ============================================================
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	// One request cycle; ack and data come one clock later
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(negedge clock);
		cfg_req = 1'b1;
		cfg_write = w;
		cfg_addr = a;
		cfg_wdata = d;
		@(negedge clock);
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		rd = cfg_rdata;
		chk("ack", 32'h00000001, {31'h0, cfg_ack});
	endtask : bus
	task rchk(input logic [31:0] a, input logic [31:0] x, input string n);
		bus(1'b0, a, 32'h00000000);
		chk(n, x, rd);
	endtask : rchk
	task clr;
		bus(1'b1, `GPP_ADDR_RISE_DELTA, 32'h0000ffff);
		bus(1'b1, `GPP_ADDR_FALL_DELTA, 32'h0000ffff);
	endtask : clr
	task test_done;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : test_done

	// ============================================================
	// Sequence
	// ============================================================
	initial begin
		sys_rst = 1'b1;
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		cfg_addr = '0;
		cfg_wdata = '0;
		ext_level = 16'h0000;
		bad_count = 0;
		checks = 0;
		repeat (4) @(negedge clock);
		sys_rst = 1'b0;
		rchk(`GPP_ADDR_ENABLE, 32'h000000ff, "enable");
		rchk(`GPP_ADDR_DIRECTION, 32'h00000000, "dir");
		bus(1'b1, `GPP_ADDR_DIRECTION, 32'hffffffff);
		rchk(`GPP_ADDR_DIRECTION, 32'h0000ffff, "dir");
		chk("oe", 32'h000000ff, {16'h0, oe});
		bus(1'b1, `GPP_ADDR_VALUE, 32'h0000a5a5);
		chk("out", 32'h000000a5, {16'h0, out_pin});
		rchk(`GPP_ADDR_VALUE, 32'h000000a5, "value");
		bus(1'b1, `GPP_ADDR_ENABLE, 32'h0000ffff);
		chk("out", 32'h0000a5a5, {16'h0, out_pin});
		bus(1'b1, 32'h01b0000c, 32'hffffffff);
		rchk(32'h01b0000c, 32'h00000000, "rsv");
		rchk(32'h01b00028, 32'h00000000, "rsv");
		bus(1'b1, `GPP_ADDR_DIRECTION, 32'h00000000);
		ext_level = 16'h1234;
		repeat (12) @(negedge clock);
		rchk(`GPP_ADDR_VALUE, 32'h00001234, "value");
		bus(1'b1, `GPP_ADDR_RISE_MASK, 32'h00000001);
		// Every mode code, dma enabled; only pin 0 rising is masked
		for (m = 0; m < 4; m++) begin
			clr();
			bus(1'b1, `GPP_ADDR_GLOBAL_CTRL, 32'h10 | m);
			e = (m == 1 || m == 2) ? 32'h1 : 32'h0;
			ne = 0;
			nd = 0;
			ext_level[0] = 1'b1;
			repeat (8) @(negedge clock);
			chk("cpu_evt", e, 32'(ne));
			chk("dma_evt", e, 32'(nd));
			ext_level[0] = 1'b0;
			repeat (8) @(negedge clock);
			chk("cpu_evt", e, 32'(ne));
			rchk(`GPP_ADDR_RISE_DELTA, 32'h00000001, "rdelta");
			rchk(`GPP_ADDR_FALL_DELTA, 32'h00000001, "fdelta");
		end
		// Swapped polarity: a rising pin lands in the falling delta
		bus(1'b1, `GPP_ADDR_POLARITY, 32'h00000001);
		clr();
		ext_level[0] = 1'b1;
		repeat (8) @(negedge clock);
		rchk(`GPP_ADDR_FALL_DELTA, 32'h00000001, "fdelta");
		rchk(`GPP_ADDR_RISE_DELTA, 32'h00000000, "rdelta");
		// Falling mask alone: only the falling pin edge raises a pulse
		bus(1'b1, `GPP_ADDR_POLARITY, 32'h00000000);
		bus(1'b1, `GPP_ADDR_RISE_MASK, 32'h00000000);
		bus(1'b1, `GPP_ADDR_FALL_MASK, 32'h00000001);
		bus(1'b1, `GPP_ADDR_GLOBAL_CTRL, 32'h00000011);
		ne = 0;
		nd = 0;
		ext_level[0] = 1'b0;
		repeat (8) @(negedge clock);
		chk("cpu_evt", 32'h00000001, 32'(ne));
		chk("dma_evt", 32'h00000001, 32'(nd));
		ext_level[0] = 1'b1;
		repeat (8) @(negedge clock);
		chk("cpu_evt", 32'h00000001, 32'(ne));
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		sys_rst = 1'b0;
		rchk(`GPP_ADDR_DIRECTION, 32'h00000000, "dir");
		chk("oe", 32'h00000000, {16'h0, oe});
		// Pins 15 to 8 disabled again: they read zero, 7 to 0 sense
		rchk(`GPP_ADDR_VALUE, 32'h00000035, "value");
		test_done();
	end
endmodule : gpio_pin_port_tb
`default_nettype wire
